// [design/rpr_raster_unit.sv]
/*
  raster pattern and raster operation unit: apb register bank, pattern
  expansion, source color expansion, transparency and ternary combine.
  assumes one apb master on sys_clk, paddr relative to the graphics base,
  and pixel requests from an outside address walker.
*/
// The APB slave port was decided locally.
`default_nettype none
module rpr_raster_unit (
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [rpr_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [rpr_pkg::DATA_W-1:0]     pwdata,
  output logic      [rpr_pkg::DATA_W-1:0]     prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire rpr_pkg::rpr_pix_req_t          pixReq,
  output rpr_pkg::rpr_pix_res_t               pixRes,
  output rpr_pkg::rpr_params_t                params,
  output logic                                vectorStart,
  output logic                                bltStart
);
  logic [31:0]           destQ;
  logic [31:0]           sizeQ;
  logic [31:0]           srcQ;
  logic [31:0]           scolQ;
  logic [31:0]           pcolLoQ;
  logic [31:0]           pcolHiQ;
  logic [31:0]           pat0Q;
  logic [31:0]           pat1Q;
  logic [31:0]           pat2Q;
  logic [31:0]           pat3Q;
  logic [31:0]           legWrQ;
  logic [31:0]           legRdQ;
  logic [31:0]           rmodeQ;
  logic [31:0]           vmodeQ;
  logic [31:0]           bmodeQ;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic                  vectorStart_q;
  logic                  bltStart_q;
  rpr_pkg::rpr_pix_res_t pixRes_q;
  rpr_pkg::rpr_pix_res_t pixRes_d;

  // apb: answer one cycle into the access phase, then accept at that edge
  wire        accessPh = psel & penable & ~pready_q;
  wire        commit   = psel & penable & pready_q;
  wire [15:0] winEnd   = rpr_pkg::WIN_BASE + rpr_pkg::WIN_SIZE;
  wire        inWin    = (paddr >= rpr_pkg::WIN_BASE) &&
                         (paddr < winEnd);
  wire        wrEn     = commit & pwrite & inWin;
  wire [13:0] wIdx     = paddr[15:2];
  wire hitDst   = wIdx == rpr_pkg::OFF_DST[15:2];
  wire hitSize  = wIdx == rpr_pkg::OFF_SIZE[15:2];
  wire hitSrc   = wIdx == rpr_pkg::OFF_SRC[15:2];
  wire hitScol  = wIdx == rpr_pkg::OFF_SCOL[15:2];
  wire hitPLo   = wIdx == rpr_pkg::OFF_PCOLLO[15:2];
  wire hitPHi   = wIdx == rpr_pkg::OFF_PCOLHI[15:2];
  wire hitPat0  = wIdx == rpr_pkg::OFF_PAT0[15:2];
  wire hitPat1  = wIdx == rpr_pkg::OFF_PAT1[15:2];
  wire hitPat2  = wIdx == rpr_pkg::OFF_PAT2[15:2];
  wire hitPat3  = wIdx == rpr_pkg::OFF_PAT3[15:2];
  wire hitLegWr = wIdx == rpr_pkg::OFF_LEGWR[15:2];
  wire hitLegRd = wIdx == rpr_pkg::OFF_LEGRD[15:2];
  wire hitRmode = wIdx == rpr_pkg::OFF_RMODE[15:2];
  wire hitVmode = wIdx == rpr_pkg::OFF_VMODE[15:2];
  wire hitBmode = wIdx == rpr_pkg::OFF_BMODE[15:2];

  // holes inside the window read as zero; outside it the slave errors
  wire [31:0] rdMux =
    hitDst   ? destQ   :
    hitSize  ? sizeQ   :
    hitSrc   ? srcQ    :
    hitScol  ? scolQ   :
    hitPLo   ? pcolLoQ :
    hitPHi   ? pcolHiQ :
    hitPat0  ? pat0Q   :
    hitPat1  ? pat1Q   :
    hitPat2  ? pat2Q   :
    hitPat3  ? pat3Q   :
    hitLegWr ? legWrQ  :
    hitLegRd ? legRdQ  :
    hitRmode ? rmodeQ  :
    hitVmode ? vmodeQ  :
    hitBmode ? bmodeQ  : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= rpr_pkg::REG_RESET;
    end else begin
      pready_q  <= accessPh;
      pslverr_q <= accessPh & ~inWin;
      if (accessPh) begin
        prdata_q <= (inWin && !pwrite) ? rdMux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      destQ   <= rpr_pkg::REG_RESET;
      sizeQ   <= rpr_pkg::REG_RESET;
      srcQ    <= rpr_pkg::REG_RESET;
      scolQ   <= rpr_pkg::REG_RESET;
      pcolLoQ <= rpr_pkg::REG_RESET;
      pcolHiQ <= rpr_pkg::REG_RESET;
      pat0Q   <= rpr_pkg::REG_RESET;
      pat1Q   <= rpr_pkg::REG_RESET;
      pat2Q   <= rpr_pkg::REG_RESET;
      pat3Q   <= rpr_pkg::REG_RESET;
      legRdQ  <= rpr_pkg::REG_RESET;
      rmodeQ  <= rpr_pkg::REG_RESET;
      vmodeQ  <= rpr_pkg::REG_RESET;
      bmodeQ  <= rpr_pkg::REG_RESET;
    end else if (wrEn) begin
      if (hitDst)   destQ   <= pwdata;
      if (hitSize)  sizeQ   <= pwdata;
      if (hitSrc)   srcQ    <= pwdata;
      if (hitScol)  scolQ   <= pwdata;
      if (hitPLo)   pcolLoQ <= pwdata;
      if (hitPHi)   pcolHiQ <= pwdata;
      if (hitPat0)  pat0Q   <= pwdata;
      if (hitPat1)  pat1Q   <= pwdata;
      if (hitPat2)  pat2Q   <= pwdata;
      if (hitPat3)  pat3Q   <= pwdata;
      if (hitLegRd) legRdQ  <= pwdata;
      if (hitRmode) rmodeQ  <= pwdata;
      if (hitVmode) vmodeQ  <= pwdata;
      if (hitBmode) bmodeQ  <= pwdata;
    end
  end

  // no reset on purpose: the legacy write control powers up undefined
  always_ff @(posedge sys_clk) begin
    if (wrEn && hitLegWr) begin
      legWrQ <= pwdata;
    end
  end

  // start pulses last one cycle; the walker latches parameters from params
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vectorStart_q <= 1'b0;
      bltStart_q    <= 1'b0;
    end else begin
      vectorStart_q <= wrEn & hitVmode;
      bltStart_q    <= wrEn & hitBmode;
    end
  end

  // mode fields
  wire [7:0]  ropCode  = rmodeQ[rpr_pkg::ROP_LSB +: 8];
  wire [1:0]  pmodeRaw = rmodeQ[rpr_pkg::PMODE_LSB +: 2];
  wire        patTrans = rmodeQ[rpr_pkg::PTRANSP_B];
  wire        srcTrans = rmodeQ[rpr_pkg::STRANSP_B];
  wire        srcExp   = rmodeQ[rpr_pkg::SEXPAND_B];
  wire        bpp16    = rmodeQ[rpr_pkg::BPP16_B];
  wire [15:0] pixMask  = bpp16 ? rpr_pkg::MASK16 : rpr_pkg::MASK8;
  rpr_pkg::rpr_pmode_t pmode;
  assign pmode = rpr_pkg::rpr_pmode_t'(pmodeRaw);

  wire [127:0] patBits = {pat3Q, pat2Q, pat1Q, pat0Q};
  wire [15:0]  patCol0 = pcolLoQ[15:0];
  wire [15:0]  patCol1 = pcolLoQ[31:16];
  wire [15:0]  patCol2 = pcolHiQ[15:0];
  wire [15:0]  patCol3 = pcolHiQ[31:16];

  // mono row: one byte per row, bit 7 at the left edge
  wire [7:0]  monoRow  = patBits[{pixReq.row, 3'b000} +: 8];
  wire [2:0]  colRev   = 3'd7 - pixReq.col;
  wire        monoBit  = monoRow[colRev];
  // dither row: low byte holds color lsb, high byte color msb
  wire [15:0] dithRow  = patBits[{pixReq.row, 4'b0000} +: 16];
  wire [1:0]  dithIdx  = {dithRow[{1'b1, colRev}], dithRow[{1'b0, colRev}]};
  wire [15:0] dithCol  = (dithIdx == 2'd0) ? patCol0 :
                         (dithIdx == 2'd1) ? patCol1 :
                         (dithIdx == 2'd2) ? patCol2 : patCol3;
  // color rows hold only one row: leftmost pixel in the lowest bits
  wire [7:0]  colPix8  = patBits[{pixReq.col, 3'b000} +: 8];
  wire [15:0] colPix16 = patBits[{pixReq.col, 4'b0000} +: 16];
  wire [15:0] colPix   = bpp16 ? colPix16 : {8'h00, colPix8};
  wire [15:0] monoCol  = monoBit ? patCol1 : patCol0;

  wire [15:0] patPix =
    (pmode == rpr_pkg::PM_COLOR)  ? colPix  :
    (pmode == rpr_pkg::PM_DITHER) ? dithCol :
    (pmode == rpr_pkg::PM_MONO)   ? monoCol : patCol0;

  wire [15:0] srcCol0 = scolQ[15:0];
  wire [15:0] srcCol1 = scolQ[31:16];
  wire [15:0] srcExpd = pixReq.srcBit ? srcCol1 : srcCol0;
  wire [15:0] srcPix  = srcExp ? srcExpd : pixReq.srcPix;

  wire [15:0] patM = patPix & pixMask;
  wire [15:0] srcM = srcPix & pixMask;
  wire [15:0] dstM = pixReq.dstPix & pixMask;
  wire [15:0] ropOut;

  rpr_ternary_rop #(
    .WIDTH (rpr_pkg::PIX_W)
  ) u_rop (
    .pat  (patM),
    .src  (srcM),
    .dst  (dstM),
    .code (ropCode),
    .res  (ropOut)
  );

  // transparent pixels still answer, but with write low
  wire patSkip = patTrans & (pmode == rpr_pkg::PM_MONO) & ~monoBit;
  wire srcSkip = srcExp & srcTrans & ~pixReq.srcBit;

  assign pixRes_d.valid = pixReq.valid;
  assign pixRes_d.write = pixReq.valid & ~(patSkip | srcSkip);
  assign pixRes_d.data  = ropOut & pixMask;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pixRes_q <= '0;
    end else begin
      pixRes_q <= pixRes_d;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign pixRes              = pixRes_q;
  assign vectorStart         = vectorStart_q;
  assign bltStart            = bltStart_q;
  assign params.destStart    = destQ;
  assign params.sizeOrLength = sizeQ;
  assign params.srcOrError   = srcQ;
  assign params.lineMode     = vmodeQ;
  assign params.blockMode    = bmodeQ;
  assign params.legacyWrite  = legWrQ;
  assign params.legacyRead   = legRdQ;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_rop_pattern: assert property (
    pixReq.valid && ropCode == rpr_pkg::ROP_PAT
    |=> pixRes_q.data == $past(patM))
    else $error("pattern code did not pass the pattern");
  a_rop_invdst: assert property (
    pixReq.valid && ropCode == rpr_pkg::ROP_NDST
    |=> pixRes_q.data == ($past(~pixReq.dstPix) & $past(pixMask)))
    else $error("inverse destination code wrong");
  a_src_expand: assert property (
    pixReq.valid && srcExp && ropCode == rpr_pkg::ROP_SRC && bpp16
    |=> pixRes_q.data == ($past(pixReq.srcBit) ? $past(scolQ[31:16])
                                               : $past(scolQ[15:0])))
    else $error("source expansion picked the wrong color");
  a_src_transp: assert property (
    pixReq.valid && srcExp && srcTrans && !pixReq.srcBit
    |=> pixRes_q.valid && !pixRes_q.write)
    else $error("transparent source pixel was written");
  a_color_left8: assert property (
    pixReq.valid && pmode == rpr_pkg::PM_COLOR && !bpp16 &&
    ropCode == rpr_pkg::ROP_PAT && pixReq.col == 3'd0
    |=> pixRes_q.data == {8'h00, $past(pat0Q[7:0])})
    else $error("8-bpp color pattern leftmost pixel wrong");
  a_color_right16: assert property (
    pixReq.valid && pmode == rpr_pkg::PM_COLOR && bpp16 &&
    ropCode == rpr_pkg::ROP_PAT && pixReq.col == 3'd7
    |=> pixRes_q.data == $past(pat3Q[31:16]))
    else $error("16-bpp color pattern rightmost pixel wrong");
  a_mono_left: assert property (
    pixReq.valid && pmode == rpr_pkg::PM_MONO && bpp16 &&
    ropCode == rpr_pkg::ROP_PAT && pixReq.col == 3'd0
    |=> pixRes_q.data == ($past(patBits[{pixReq.row, 3'b111}])
                          ? $past(pcolLoQ[31:16]) : $past(pcolLoQ[15:0])))
    else $error("mono pattern leftmost pixel wrong");
  a_vector_go: assert property (
    wrEn && hitVmode |=> vectorStart_q ##1 !vectorStart_q)
    else $error("vector start pulse missing or too long");
  a_blt_go: assert property (
    wrEn && hitBmode |=> bltStart_q && bmodeQ == $past(pwdata))
    else $error("block copy start pulse missing");
  a_window_err: assert property (
    accessPh && !inWin |=> pready_q && pslverr_q)
    else $error("access outside window not flagged");
  a_dest_read: assert property (
    accessPh && !pwrite && hitDst && inWin |=> prdata_q == $past(destQ))
    else $error("destination register read back wrong");
  a_color_mid8: assert property (
    pixReq.valid && pmode == rpr_pkg::PM_COLOR && !bpp16 &&
    ropCode == rpr_pkg::ROP_PAT && pixReq.col == 3'd5
    |=> pixRes_q.data == {8'h00, $past(pat1Q[15:8])})
    else $error("8-bpp color pattern sixth pixel wrong");
  a_src_xor: assert property (
    pixReq.valid && ropCode == rpr_pkg::ROP_SXD && !srcExp
    |=> pixRes_q.data == $past((pixReq.srcPix ^ pixReq.dstPix) & pixMask))
    else $error("source xor destination code wrong");
  a_pat_xor: assert property (
    pixReq.valid && ropCode == rpr_pkg::ROP_PXD && pmode == rpr_pkg::PM_SOLID
    |=> pixRes_q.data == ($past(pcolLoQ[15:0] ^ pixReq.dstPix) &
                          $past(pixMask)))
    else $error("pattern xor destination code wrong");
  // four colors side by side, so the check picks one by its own index
  wire [63:0] patColAll = {pcolHiQ, pcolLoQ};
  a_dither_left: assert property (
    pixReq.valid && pmode == rpr_pkg::PM_DITHER && bpp16 &&
    ropCode == rpr_pkg::ROP_PAT && pixReq.col == 3'd0
    |=> pixRes_q.data == $past(patColAll[{patBits[{pixReq.row, 4'hF}],
                          patBits[{pixReq.row, 4'h7}], 4'h0} +: 16]))
    else $error("dither pattern leftmost pixel wrong");
  a_src_write: assert property (
    pixReq.valid && srcExp && srcTrans && pixReq.srcBit && !patTrans
    |=> pixRes_q.valid && pixRes_q.write)
    else $error("opaque source pixel was not written");
  a_pat_store: assert property (
    wrEn && hitPat3 |=> pat3Q == $past(pwdata))
    else $error("pattern word three not stored");
  a_size_store: assert property (
    wrEn && hitSize |=> sizeQ == $past(pwdata))
    else $error("size register not stored");
  a_src_store: assert property (
    wrEn && hitSrc |=> srcQ == $past(pwdata))
    else $error("source register not stored");
endmodule
`default_nettype wire

// [design/rpr_pkg.sv]
/*
  constants, field layouts and carrier types of the raster pattern and
  raster operation unit.
  assumes register offsets are seen relative to the graphics base address.
*/
`default_nettype none
package rpr_pkg;
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 32;
  localparam int          PIX_W      = 16;
  localparam logic [15:0] WIN_BASE   = 16'h8100;
  localparam logic [15:0] WIN_SIZE   = 16'h0200;
  localparam logic [15:0] OFF_DST    = 16'h8100;
  localparam logic [15:0] OFF_SIZE   = 16'h8104;
  localparam logic [15:0] OFF_SRC    = 16'h8108;
  localparam logic [15:0] OFF_SCOL   = 16'h810C;
  localparam logic [15:0] OFF_PCOLLO = 16'h8110;
  localparam logic [15:0] OFF_PCOLHI = 16'h8114;
  localparam logic [15:0] OFF_PAT0   = 16'h8120;
  localparam logic [15:0] OFF_PAT1   = 16'h8124;
  localparam logic [15:0] OFF_PAT2   = 16'h8128;
  localparam logic [15:0] OFF_PAT3   = 16'h812C;
  localparam logic [15:0] OFF_LEGWR  = 16'h8140;
  localparam logic [15:0] OFF_LEGRD  = 16'h8144;
  localparam logic [15:0] OFF_RMODE  = 16'h8200;
  localparam logic [15:0] OFF_VMODE  = 16'h8204;
  localparam logic [15:0] OFF_BMODE  = 16'h8208;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  // pixel_combine_mode fields
  localparam int          ROP_LSB    = 0;
  localparam int          PMODE_LSB  = 8;
  localparam int          PTRANSP_B  = 10;
  localparam int          STRANSP_B  = 11;
  localparam int          SEXPAND_B  = 12;
  localparam int          BPP16_B    = 13;
  // common operation codes
  localparam logic [7:0]  ROP_PAT    = 8'hF0;
  localparam logic [7:0]  ROP_SRC    = 8'hCC;
  localparam logic [7:0]  ROP_PXD    = 8'h5A;
  localparam logic [7:0]  ROP_SXD    = 8'h66;
  localparam logic [7:0]  ROP_NDST   = 8'h55;
  localparam logic [15:0] MASK8      = 16'h00FF;
  localparam logic [15:0] MASK16     = 16'hFFFF;

  typedef enum logic [1:0] {
    PM_SOLID,
    PM_MONO,
    PM_DITHER,
    PM_COLOR
  } rpr_pmode_t;

  typedef struct packed {
    logic             valid;
    logic [2:0]       col;
    logic [2:0]       row;
    logic             srcBit;
    logic [PIX_W-1:0] srcPix;
    logic [PIX_W-1:0] dstPix;
  } rpr_pix_req_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [PIX_W-1:0] data;
  } rpr_pix_res_t;

  typedef struct packed {
    logic [31:0] destStart;
    logic [31:0] sizeOrLength;
    logic [31:0] srcOrError;
    logic [31:0] lineMode;
    logic [31:0] blockMode;
    logic [31:0] legacyWrite;
    logic [31:0] legacyRead;
  } rpr_params_t;
endpackage
`default_nettype wire

// [design/rpr_ternary_rop.sv]
/*
  bitwise three-input raster operation over a word of any width.
  assumes the code is stable for the cycle in which the output is used.
*/
`default_nettype none
module rpr_ternary_rop #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] pat,
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] dst,
  input  wire logic [7:0]       code,
  output logic      [WIDTH-1:0] res
);
  // every bit looks up the code with its own pattern, source, dest triple
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign res[i] = code[{pat[i], src[i], dst[i]}];
  end
endmodule
`default_nettype wire

// [verif/rpr_tb.sv]
/*
  self-checking bench of the raster pattern and raster operation unit,
  with a register shadow and a pixel model built from integers and queues.
  assumes one wait state on apb and a one-cycle pixel answer.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       sys_clk = 1'h0;
  logic                       resetn = 1'h0;
  logic                       psel = 1'h0;
  logic                       penable = 1'h0;
  logic                       pwrite = 1'h0;
  logic [rpr_pkg::ADDR_W-1:0] paddr = 16'h0;
  logic [rpr_pkg::DATA_W-1:0] pwdata = 32'h0;
  logic [rpr_pkg::DATA_W-1:0] prdata;
  logic                       pready;
  logic                       pslverr;
  rpr_pkg::rpr_pix_req_t      pixReq = '0;
  rpr_pkg::rpr_pix_res_t      pixRes;
  rpr_pkg::rpr_params_t       params;
  logic                       vectorStart;
  logic                       bltStart;
  int                         fails = 0;
  int                         nTests = 0;
  logic [31:0]                shadow [int];
  logic [17:0]                expQ [$];
  logic [15:0]                regList [15] = '{16'h8100, 16'h8104, 16'h8108,
    16'h810C, 16'h8110, 16'h8114, 16'h8120, 16'h8124, 16'h8128, 16'h812C,
    16'h8140, 16'h8144, 16'h8200, 16'h8204, 16'h8208};
  logic [15:0]                holeList [6] = '{16'h8118, 16'h8130, 16'h820C,
    16'h82FC, 16'h80FC, 16'h8300};
  logic [7:0]                 ropList [5] = '{8'hF0, 8'hCC, 8'h5A, 8'h66,
    8'h55};

  rpr_raster_unit dut (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .pixReq      (pixReq),
    .pixRes      (pixRes),
    .params      (params),
    .vectorStart (vectorStart),
    .bltStart    (bltStart)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic final_report();
    if (fails == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples pready, released only after it
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    // no limit here: only the watchdog may end a wait
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk(32'(k), 32'h2);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'h1, a, d, rd, er);
    if (shadow.exists(int'(a)) || a == 16'h8140) shadow[int'(a)] = d;
  endtask

  task automatic rd_chk(input logic [15:0] a);
    logic [31:0] rd;
    logic        er;
    apb(1'h0, a, 32'h0, rd, er);
    chk(rd, shadow.exists(int'(a)) ? shadow[int'(a)] : 32'h0);
    chk({31'h0, er}, {31'h0, a < 16'h8100 || a > 16'h82FF});
  endtask

  // the legacy write control has no reset value, so it is left out
  task automatic reset_chk();
    foreach (regList[i]) if (regList[i] != 16'h8140) shadow[regList[i]] = 0;
    foreach (regList[i])
      if (regList[i] != 16'h8140) rd_chk(regList[i]);
  endtask

  task automatic start_chk(input logic [15:0] a);
    wr(a, $urandom());
    @(posedge sys_clk);
    chk({30'h0, vectorStart, bltStart},
        {30'h0, a == 16'h8204, a == 16'h8208});
    @(posedge sys_clk);
    chk({30'h0, vectorStart, bltStart}, 32'h0);
  endtask

  function automatic logic [17:0] model(input rpr_pkg::rpr_pix_req_t r);
    logic [31:0]  m;
    logic [127:0] pt;
    logic [63:0]  pc;
    logic [15:0]  p, s, d, mk, o;
    logic         mb, w;
    int           rw, cl;
    m = shadow[16'h8200];
    pt = {shadow[16'h812C], shadow[16'h8128], shadow[16'h8124],
          shadow[16'h8120]};
    pc = {shadow[16'h8114], shadow[16'h8110]};
    rw = int'(r.row);
    cl = int'(r.col);
    mb = pt[rw * 8 + 7 - cl];
    case (m[9:8])
      2'h0: p = pc[15:0];
      2'h1: p = pc[int'(mb) * 16 +: 16];
      2'h2: p = pc[int'({pt[rw*16+15-cl], pt[rw*16+7-cl]}) * 16 +: 16];
      default: p = m[13] ? pt[cl * 16 +: 16] : {8'h0, pt[cl * 8 +: 8]};
    endcase
    s = !m[12] ? r.srcPix : (r.srcBit ? shadow[16'h810C][31:16]
                                      : shadow[16'h810C][15:0]);
    d = r.dstPix;
    mk = m[13] ? 16'hFFFF : 16'h00FF;
    for (int i = 0; i < 16; i++) o[i] = m[{p[i], s[i], d[i]}];
    w = !((m[12] & m[11] & !r.srcBit) | (m[9:8] == 2'h1 & m[10] & !mb));
    return {1'h1, w, o & mk};
  endfunction

  // answers are read two edges after the edge that drives the request
  task automatic pix_run(input logic [31:0] mode, input int n);
    rpr_pkg::rpr_pix_req_t r;
    wr(16'h8200, mode);
    for (int k = 0; k < n + 2; k++) begin
      @(posedge sys_clk);
      if (k >= 2) chk({14'h0, pixRes}, {14'h0, expQ.pop_front()});
      r = '0;
      if (k < n) begin
        r.valid = 1'h1;
        r.col = 3'($urandom());
        r.row = 3'($urandom());
        r.srcBit = 1'($urandom());
        r.srcPix = 16'($urandom());
        r.dstPix = 16'($urandom());
        expQ.push_back(model(r));
      end
      pixReq <= r;
    end
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  initial begin
    void'($urandom(32'h8510));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'h1;
    reset_chk();
    foreach (regList[i]) wr(regList[i], $urandom());
    foreach (regList[i]) rd_chk(regList[i]);
    chk(params.destStart, shadow[16'h8100]);
    chk(params.sizeOrLength, shadow[16'h8104]);
    chk(params.srcOrError, shadow[16'h8108]);
    chk(params.legacyWrite, shadow[16'h8140]);
    chk(params.legacyRead, shadow[16'h8144]);
    // a reset in mid-run must clear what the writes above loaded, except the legacy write control
    resetn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    reset_chk();
    foreach (holeList[i]) wr(holeList[i], $urandom());
    foreach (holeList[i]) rd_chk(holeList[i]);
    start_chk(16'h8204);
    start_chk(16'h8208);
    chk(params.lineMode, shadow[16'h8204]);
    chk(params.blockMode, shadow[16'h8208]);
    for (int b = 0; b < 2; b++)
      foreach (ropList[i])
        pix_run({18'h0, 1'(b), 5'h0, ropList[i]}, 8);
    pix_run(32'h000001F0, 24);
    pix_run(32'h000025F0, 24);
    pix_run(32'h000022F0, 24);
    for (int b = 0; b < 2; b++)
      for (int row = 0; row < 8; row++) begin
        for (int j = 0; j < 4; j++)
          wr(16'h8120 + 16'(4 * j), $urandom());
        pix_run({18'h0, 1'(b), 5'h3, 8'hF0}, 8);
      end
    pix_run(32'h000010CC, 16);
    pix_run(32'h000018CC, 16);
    pix_run(32'h000038CC, 16);
    repeat (8) pix_run({18'h0, 14'($urandom())}, 12);
    final_report();
  end
endmodule
`default_nettype wire
